//--- hw/caod_defines.svh
`ifndef CAOD_DEFINES_SVH
`define CAOD_DEFINES_SVH

// Special function register byte addresses
`define CAOD_SFR_SP        8'h81
`define CAOD_SFR_DPL       8'h82
`define CAOD_SFR_DPH       8'h83
`define CAOD_SFR_PSW       8'hD0
`define CAOD_SFR_ACC       8'hE0
`define CAOD_SFR_B         8'hF0

// Status word field positions
`define CAOD_PSW_CY        7
`define CAOD_PSW_AC        6
`define CAOD_PSW_RS_HI     4
`define CAOD_PSW_RS_LO     3
`define CAOD_PSW_OV        2
`define CAOD_PSW_P         0

// Reset values
`define CAOD_PC_RST        16'h0000
`define CAOD_SP_RST        8'h07
`define CAOD_BYTE_RST      8'h00

// Flag bit area base in lower RAM
`define CAOD_BIT_BASE      8'h20

// Opcode groups (high nibble) and operand forms (low nibble)
`define CAOD_GRP_INC       4'h0
`define CAOD_GRP_DEC       4'h1
`define CAOD_GRP_ADD       4'h2
`define CAOD_GRP_ADD_WITH_CARRY_OP      4'h3
`define CAOD_GRP_SUBTRACT_WITH_BORROW_OP      4'h9
`define CAOD_LO_IMM        4'h4
`define CAOD_LO_DIR        4'h5
`define CAOD_LO_IND        3'h3

// Whole opcodes, and the low five bits of the absolute jump and call opcodes
`define CAOD_OP_LJMP       8'h02
`define CAOD_OP_LCALL      8'h12
`define CAOD_OP_JB         8'h20
`define CAOD_OP_JNB        8'h30
`define CAOD_OP_JC         8'h40
`define CAOD_OP_JNC        8'h50
`define CAOD_OP_JZ         8'h60
`define CAOD_OP_JNZ        8'h70
`define CAOD_OP_SJMP       8'h80
`define CAOD_OP_DIV        8'h84
`define CAOD_OP_INC_DATA_POINTER_16   8'hA3
`define CAOD_OP_MUL        8'hA4
`define CAOD_OP_DA         8'hD4
`define CAOD_OP_AJMP_LO    5'h01
`define CAOD_OP_ACALL_LO   5'h11

// Decimal adjust constants
`define CAOD_BCD_MAX       4'h9
`define CAOD_BCD_ADJ_LO    9'h006
`define CAOD_BCD_ADJ_HI    9'h060

`endif

//--- hw/caod_pkg.sv
package caod_pkg;

   typedef enum logic [2:0] {
      ST_FETCH,
      ST_OPND,
      ST_DISP,
      ST_PTR,
      ST_EXEC,
      ST_PUSH
   } caod_state_type;

   typedef enum logic [2:0] {
      FORM_NONE,
      FORM_IMM,
      FORM_REG,
      FORM_DIR,
      FORM_IND,
      FORM_BIT
   } caod_form_type;

endpackage : caod_pkg

//--- hw/caod_iram.sv
`timescale 1ns/1ps
module caod_iram #(
   parameter int AW = 8,
   parameter int DW = 8
) (
   // Clock
   input  wire logic          mclk,
   // Access port
   input  wire logic [AW-1:0] addr,
   input  wire logic          we,
   input  wire logic [DW-1:0] wdata,
   output logic      [DW-1:0] rdata
);

   logic [DW-1:0] mem [0:(1<<AW)-1];
   logic [DW-1:0] rdata_r;

   always_ff @(posedge mclk) begin
      if (we) begin
         mem[addr] <= wdata;
      end
      rdata_r <= mem[addr];
   end

   assign rdata = rdata_r;

endmodule : caod_iram

//--- hw/caod_core.sv
// How it works
// - A working-register operand picks one of eight registers R0 to R7 in the current bank.
// - A direct operand reaches lower RAM below 128 or, from 128 up, a special function register.
// - An indirect operand reads R0 or R1 and uses its content as the RAM address.
// - A short immediate is one 8-bit code byte that follows the opcode.
// - A bit operand names one of 128 flags in RAM or a flag of a bit-addressable register.
// - Long jump and long call load the full 16-bit target anywhere in 64 Kbyte of code.
// - Absolute jump and call keep the 2-Kbyte page of the next instruction and take 11 bits.
// - Short and conditional jumps add a signed 8-bit offset to the next instruction address.
// - Add puts accumulator plus a register, direct, indirect or immediate source in A.
// - Add with carry also adds the carry flag, for all four source forms.
// - Subtract with borrow takes the source and the carry from A, for all four forms.
// - Increment works on A, a register, a direct or indirect location and the data pointer.
// - Decrement works on A, a register, a direct location or an indirect location.
// - Opcodes, operand order and flag effects follow the standard 8051 instruction set.
`timescale 1ns/1ps
`include "caod_defines.svh"
module caod_core
   import caod_pkg::*;
#(
   parameter int RAM_AW = 8
) (
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        sys_rst,
   // Code fetch
   output logic      [15:0] code_addr,
   output logic             code_rd,
   input  wire logic        code_valid,
   input  wire logic [7:0]  code_data,
   // Architectural state
   output logic      [7:0]  acc_out,
   output logic      [7:0]  b_out,
   output logic      [7:0]  psw_out,
   output logic      [7:0]  sp_out,
   output logic      [15:0] data_pointer_16,
   output logic             insn_done
);

   caod_state_type state_r, state_nxt;
   logic [15:0]    pc_r, pc_nxt;
   logic [7:0]     op_r, op_nxt;
   logic [7:0]     b1_r, b1_nxt;
   logic [7:0]     b2_r, b2_nxt;
   logic [1:0]     cnt_r, cnt_nxt;
   logic [7:0]     tgt_r, tgt_nxt;
   logic           is_sfr_r, is_sfr_nxt;
   logic [7:0]     ret_hi_r, ret_hi_nxt;
   logic [7:0]     acc_r, acc_nxt;
   logic [7:0]     b_r, b_nxt;
   logic [7:0]     psw_r, psw_nxt;
   logic [7:0]     sp_r, sp_nxt;
   logic [15:0]    data_pointer_16_r, data_pointer_16_nxt;
   logic           done_r, done_nxt;

   logic [RAM_AW-1:0] ram_addr;
   logic              ram_we;
   logic [7:0]        ram_wdata;
   logic [7:0]        ram_rdata;

   caod_iram #(.AW(RAM_AW), .DW(8)) u_iram (
      .mclk  (mclk),
      .addr  (ram_addr),
      .we    (ram_we),
      .wdata (ram_wdata),
      .rdata (ram_rdata)
   );

   // Extra code bytes after the opcode
   function automatic logic [1:0] caod_len(input logic [7:0] op);
      logic [1:0] n;
      n = 2'd0;
      if ((op[7:4] == `CAOD_GRP_ADD || op[7:4] == `CAOD_GRP_ADD_WITH_CARRY_OP ||
           op[7:4] == `CAOD_GRP_SUBTRACT_WITH_BORROW_OP) && op[3:0] == `CAOD_LO_IMM) begin
         n = 2'd1;
      end else if ((op[7:4] == `CAOD_GRP_ADD || op[7:4] == `CAOD_GRP_ADD_WITH_CARRY_OP ||
                    op[7:4] == `CAOD_GRP_SUBTRACT_WITH_BORROW_OP || op[7:4] == `CAOD_GRP_INC ||
                    op[7:4] == `CAOD_GRP_DEC) && op[3:0] == `CAOD_LO_DIR) begin
         n = 2'd1;
      end else if (op == `CAOD_OP_LJMP || op == `CAOD_OP_LCALL ||
                   op == `CAOD_OP_JB || op == `CAOD_OP_JNB) begin
         n = 2'd2;
      end else if (op[4:0] == `CAOD_OP_AJMP_LO || op[4:0] == `CAOD_OP_ACALL_LO ||
                   op == `CAOD_OP_SJMP || op == `CAOD_OP_JC || op == `CAOD_OP_JNC ||
                   op == `CAOD_OP_JZ || op == `CAOD_OP_JNZ) begin
         n = 2'd1;
      end
      return n;
   endfunction : caod_len

   logic [3:0]    hi;
   logic [3:0]    lo;
   logic          arith;
   logic          incdec;
   caod_form_type form;
   logic [1:0]    rs;
   logic [7:0]    sfr_rd;
   logic [7:0]    mem_byte;
   logic [7:0]    opv;
   logic          cy;
   logic          cin;
   logic [8:0]    sum9;
   logic [4:0]    sum5;
   logic [8:0]    dif9;
   logic [4:0]    dif5;
   logic [15:0]   prod;
   logic [8:0]    da1;
   logic [8:0]    da2;
   logic          da_c1;
   logic [7:0]    res;
   logic          bitv;
   logic          take;
   logic [7:0]    rel;
   logic [15:0]   rel_tgt;

   // Opcode decode
   always_comb begin
      hi     = op_r[7:4];
      lo     = op_r[3:0];
      rs     = psw_r[`CAOD_PSW_RS_HI:`CAOD_PSW_RS_LO];
      incdec = (hi == `CAOD_GRP_INC || hi == `CAOD_GRP_DEC) && lo >= `CAOD_LO_IMM;
      arith  = (hi == `CAOD_GRP_ADD || hi == `CAOD_GRP_ADD_WITH_CARRY_OP || hi == `CAOD_GRP_SUBTRACT_WITH_BORROW_OP) &&
               lo >= `CAOD_LO_IMM;
      form   = FORM_NONE;
      if (incdec || arith) begin
         if (lo == `CAOD_LO_IMM) begin
            form = arith ? FORM_IMM : FORM_NONE;
         end else if (lo == `CAOD_LO_DIR) begin
            form = FORM_DIR;
         end else if (lo[3:1] == `CAOD_LO_IND) begin
            form = FORM_IND;
         end else begin
            form = FORM_REG;
         end
      end else if (op_r == `CAOD_OP_JB || op_r == `CAOD_OP_JNB) begin
         form = FORM_BIT;
      end
   end

   // Special function register read, unmapped addresses read zero
   always_comb begin
      case (tgt_r)
         `CAOD_SFR_ACC: sfr_rd = acc_r;
         `CAOD_SFR_B:   sfr_rd = b_r;
         `CAOD_SFR_PSW: sfr_rd = psw_r;
         `CAOD_SFR_SP:  sfr_rd = sp_r;
         `CAOD_SFR_DPL: sfr_rd = data_pointer_16_r[7:0];
         `CAOD_SFR_DPH: sfr_rd = data_pointer_16_r[15:8];
         default:       sfr_rd = `CAOD_BYTE_RST;
      endcase
   end

   // Arithmetic datapath
   always_comb begin
      cy       = psw_r[`CAOD_PSW_CY];
      mem_byte = is_sfr_r ? sfr_rd : ram_rdata;
      opv      = (form == FORM_IMM) ? b1_r : mem_byte;
      if (lo == `CAOD_LO_IMM && incdec) begin
         opv = acc_r;
      end
      cin   = (hi == `CAOD_GRP_ADD) ? 1'b0 : cy;
      sum9  = {1'b0, acc_r} + {1'b0, opv} + {8'h00, cin};
      sum5  = {1'b0, acc_r[3:0]} + {1'b0, opv[3:0]} + {4'h0, cin};
      dif9  = {1'b0, acc_r} - {1'b0, opv} - {8'h00, cin};
      dif5  = {1'b0, acc_r[3:0]} - {1'b0, opv[3:0]} - {4'h0, cin};
      prod  = acc_r * b_r;
      da1   = (acc_r[3:0] > `CAOD_BCD_MAX || psw_r[`CAOD_PSW_AC]) ?
              {1'b0, acc_r} + `CAOD_BCD_ADJ_LO : {1'b0, acc_r};
      da_c1 = cy | da1[8];
      da2   = (da1[7:4] > `CAOD_BCD_MAX || da_c1) ?
              {1'b0, da1[7:0]} + `CAOD_BCD_ADJ_HI : {1'b0, da1[7:0]};
      res   = (hi == `CAOD_GRP_INC) ? opv + 8'h01 : opv - 8'h01;
      bitv  = mem_byte[b1_r[2:0]];
      rel   = (form == FORM_BIT) ? b2_r : b1_r;
      rel_tgt = pc_r + {{8{rel[7]}}, rel};
      case (op_r)
         `CAOD_OP_SJMP: take = 1'b1;
         `CAOD_OP_JC:   take = cy;
         `CAOD_OP_JNC:  take = ~cy;
         `CAOD_OP_JZ:   take = (acc_r == 8'h00);
         `CAOD_OP_JNZ:  take = (acc_r != 8'h00);
         `CAOD_OP_JB:   take = bitv;
         `CAOD_OP_JNB:  take = ~bitv;
         default:       take = 1'b0;
      endcase
   end

   // Sequencer and architectural state
   always_comb begin
      state_nxt  = state_r;
      pc_nxt     = pc_r;
      op_nxt     = op_r;
      b1_nxt     = b1_r;
      b2_nxt     = b2_r;
      cnt_nxt    = cnt_r;
      tgt_nxt    = tgt_r;
      is_sfr_nxt = is_sfr_r;
      ret_hi_nxt = ret_hi_r;
      acc_nxt    = acc_r;
      b_nxt      = b_r;
      psw_nxt    = psw_r;
      sp_nxt     = sp_r;
      data_pointer_16_nxt   = data_pointer_16_r;
      done_nxt   = 1'b0;
      code_rd    = 1'b0;
      ram_addr   = tgt_r;
      ram_we     = 1'b0;
      ram_wdata  = res;
      case (state_r)
         ST_FETCH: begin
            code_rd = 1'b1;
            if (code_valid) begin
               op_nxt    = code_data;
               pc_nxt    = pc_r + 16'h0001;
               cnt_nxt   = caod_len(code_data);
               state_nxt = (caod_len(code_data) != 2'd0) ? ST_OPND : ST_DISP;
            end
         end
         ST_OPND: begin
            code_rd = 1'b1;
            if (code_valid) begin
               if (cnt_r == caod_len(op_r)) begin
                  b1_nxt = code_data;
               end else begin
                  b2_nxt = code_data;
               end
               pc_nxt  = pc_r + 16'h0001;
               cnt_nxt = cnt_r - 2'd1;
               if (cnt_r == 2'd1) begin
                  state_nxt = ST_DISP;
               end
            end
         end
         ST_DISP: begin
            state_nxt  = ST_EXEC;
            is_sfr_nxt = 1'b0;
            case (form)
               FORM_REG: tgt_nxt = {3'b000, rs, op_r[2:0]};
               FORM_DIR: begin
                  tgt_nxt    = b1_r;
                  is_sfr_nxt = b1_r[7];
               end
               FORM_IND: begin
                  tgt_nxt   = {3'b000, rs, 2'b00, op_r[0]};
                  state_nxt = ST_PTR;
               end
               FORM_BIT: begin
                  tgt_nxt    = b1_r[7] ? {b1_r[7:3], 3'b000} :
                               `CAOD_BIT_BASE + {4'h0, b1_r[6:3]};
                  is_sfr_nxt = b1_r[7];
               end
               default: tgt_nxt = tgt_r;
            endcase
            ram_addr = tgt_nxt;
         end
         ST_PTR: begin
            tgt_nxt   = ram_rdata;
            ram_addr  = ram_rdata;
            state_nxt = ST_EXEC;
         end
         ST_EXEC: begin
            done_nxt  = 1'b1;
            state_nxt = ST_FETCH;
            if (arith) begin
               if (hi == `CAOD_GRP_SUBTRACT_WITH_BORROW_OP) begin
                  acc_nxt                 = dif9[7:0];
                  psw_nxt[`CAOD_PSW_CY]   = dif9[8];
                  psw_nxt[`CAOD_PSW_AC]   = dif5[4];
                  psw_nxt[`CAOD_PSW_OV]   = (acc_r[7] != opv[7]) && (dif9[7] != acc_r[7]);
               end else begin
                  acc_nxt                 = sum9[7:0];
                  psw_nxt[`CAOD_PSW_CY]   = sum9[8];
                  psw_nxt[`CAOD_PSW_AC]   = sum5[4];
                  psw_nxt[`CAOD_PSW_OV]   = (acc_r[7] == opv[7]) && (sum9[7] != acc_r[7]);
               end
            end else if (incdec) begin
               if (lo == `CAOD_LO_IMM) begin
                  acc_nxt = res;
               end else if (is_sfr_r) begin
                  case (tgt_r)
                     `CAOD_SFR_ACC: acc_nxt = res;
                     `CAOD_SFR_B:   b_nxt = res;
                     `CAOD_SFR_PSW: psw_nxt = res;
                     `CAOD_SFR_SP:  sp_nxt = res;
                     `CAOD_SFR_DPL: data_pointer_16_nxt[7:0] = res;
                     `CAOD_SFR_DPH: data_pointer_16_nxt[15:8] = res;
                     default:       ;
                  endcase
               end else begin
                  ram_we = 1'b1;
               end
            end else begin
               case (op_r)
                  `CAOD_OP_INC_DATA_POINTER_16: data_pointer_16_nxt = data_pointer_16_r + 16'h0001;
                  `CAOD_OP_MUL: begin
                     acc_nxt               = prod[7:0];
                     b_nxt                 = prod[15:8];
                     psw_nxt[`CAOD_PSW_CY] = 1'b0;
                     psw_nxt[`CAOD_PSW_OV] = (prod[15:8] != 8'h00);
                  end
                  `CAOD_OP_DIV: begin
                     psw_nxt[`CAOD_PSW_CY] = 1'b0;
                     psw_nxt[`CAOD_PSW_OV] = (b_r == 8'h00);
                     if (b_r != 8'h00) begin
                        acc_nxt = acc_r / b_r;
                        b_nxt   = acc_r % b_r;
                     end
                  end
                  `CAOD_OP_DA: begin
                     acc_nxt               = da2[7:0];
                     psw_nxt[`CAOD_PSW_CY] = da_c1 | da2[8];
                  end
                  `CAOD_OP_LJMP: pc_nxt = {b1_r, b2_r};
                  `CAOD_OP_LCALL: begin
                     pc_nxt = {b1_r, b2_r};
                  end
                  default: begin
                     if (op_r[4:0] == `CAOD_OP_AJMP_LO || op_r[4:0] == `CAOD_OP_ACALL_LO) begin
                        pc_nxt = {pc_r[15:11], op_r[7:5], b1_r};
                     end else if (take) begin
                        pc_nxt = rel_tgt;
                     end
                  end
               endcase
               // Calls push the return address low byte first
               if (op_r == `CAOD_OP_LCALL || op_r[4:0] == `CAOD_OP_ACALL_LO) begin
                  ram_addr   = sp_r + 8'h01;
                  ram_wdata  = pc_r[7:0];
                  ram_we     = 1'b1;
                  sp_nxt     = sp_r + 8'h01;
                  ret_hi_nxt = pc_r[15:8];
                  done_nxt   = 1'b0;
                  state_nxt  = ST_PUSH;
               end
            end
         end
         ST_PUSH: begin
            ram_addr  = sp_r + 8'h01;
            ram_wdata = ret_hi_r;
            ram_we    = 1'b1;
            sp_nxt    = sp_r + 8'h01;
            done_nxt  = 1'b1;
            state_nxt = ST_FETCH;
         end
         default: state_nxt = ST_FETCH;
      endcase
      psw_nxt[`CAOD_PSW_P] = ^acc_nxt;
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         state_r  <= ST_FETCH;
         pc_r     <= `CAOD_PC_RST;
         op_r     <= `CAOD_BYTE_RST;
         b1_r     <= `CAOD_BYTE_RST;
         b2_r     <= `CAOD_BYTE_RST;
         cnt_r    <= 2'd0;
         tgt_r    <= `CAOD_BYTE_RST;
         is_sfr_r <= 1'b0;
         ret_hi_r <= `CAOD_BYTE_RST;
         acc_r    <= `CAOD_BYTE_RST;
         b_r      <= `CAOD_BYTE_RST;
         psw_r    <= `CAOD_BYTE_RST;
         sp_r     <= `CAOD_SP_RST;
         data_pointer_16_r   <= `CAOD_PC_RST;
         done_r   <= 1'b0;
      end else begin
         state_r  <= state_nxt;
         pc_r     <= pc_nxt;
         op_r     <= op_nxt;
         b1_r     <= b1_nxt;
         b2_r     <= b2_nxt;
         cnt_r    <= cnt_nxt;
         tgt_r    <= tgt_nxt;
         is_sfr_r <= is_sfr_nxt;
         ret_hi_r <= ret_hi_nxt;
         acc_r    <= acc_nxt;
         b_r      <= b_nxt;
         psw_r    <= psw_nxt;
         sp_r     <= sp_nxt;
         data_pointer_16_r   <= data_pointer_16_nxt;
         done_r   <= done_nxt;
      end
   end

   assign code_addr       = pc_r;
   assign acc_out         = acc_r;
   assign b_out           = b_r;
   assign psw_out         = psw_r;
   assign sp_out          = sp_r;
   assign data_pointer_16 = data_pointer_16_r;
   assign insn_done       = done_r;

endmodule : caod_core

//--- verif/caod_core_props.sv
`timescale 1ns/1ps
module caod_core_props (
   // Clock and reset
   input wire logic        mclk,
   input wire logic        sys_rst,
   // Code fetch
   input wire logic [15:0] code_addr,
   input wire logic        code_rd,
   input wire logic        code_valid,
   input wire logic [7:0]  code_data,
   // Architectural state
   input wire logic [7:0]  acc_out,
   input wire logic [7:0]  b_out,
   input wire logic [7:0]  psw_out,
   input wire logic [7:0]  sp_out,
   input wire logic [15:0] data_pointer_16,
   input wire logic        insn_done
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (sys_rst);

   a_reset_state: assert property ($fell(sys_rst) |->
      code_addr == 16'h0000 && sp_out == 8'h07 && acc_out == 8'h00)
      else $error("state after reset release is wrong");
   a_parity_follows: assert property (psw_out[0] == ^acc_out)
      else $error("parity flag does not follow accumulator");
   a_arch_on_retire: assert property (($changed(acc_out) || $changed(b_out) ||
      $changed(psw_out) || $changed(data_pointer_16)) |-> insn_done)
      else $error("state changed outside retire");
   a_done_spacing: assert property (insn_done |=> !insn_done [*2])
      else $error("retire pulses too close");
   a_fetch_hold: assert property (code_rd && !code_valid |=>
      code_rd && $stable(code_addr))
      else $error("fetch request dropped while waiting");
   a_fetch_step: assert property (code_rd && code_valid |=>
      code_addr == $past(code_addr) + 16'h0001)
      else $error("fetch address did not step by one");
   a_decode_gap: assert property ($fell(code_rd) |-> ##1 !code_rd ##[1:3] code_rd)
      else $error("fetch pause outside two to four cycles");
   a_done_with_fetch: assert property (insn_done == $rose(code_rd))
      else $error("retire pulse not aligned with next fetch");

   c_stall: cover property (code_rd && !code_valid);
   c_long_gap: cover property ($fell(code_rd) ##1 !code_rd ##1 !code_rd);
   c_sp_move: cover property ($changed(sp_out));
endmodule : caod_core_props

//--- verif/cpu_arith_operand_decode_bench.sv
`timescale 1ns/1ps
module cpu_arith_operand_decode_bench;
   typedef struct packed {
      logic [7:0]  a, b, p, s;
      logic [15:0] d, pc;
   } caod_note_type;
   logic          mclk = 1'b0;
   logic          sys_rst = 1'b1;
   logic          code_valid = 1'b0;
   logic [7:0]    code_data = 8'h00;
   logic [15:0]   code_addr, data_pointer_16, pc, mdp, p;
   logic [7:0]    acc_out, b_out, psw_out, sp_out, ma, mb, msp, v, t;
   logic          code_rd, insn_done, mcy, mac, mov, fv;
   logic [8:0]    w;
   logic [7:0]    rom [0:65535];
   logic [7:0]    ram [0:255];
   logic [7:0]    grp [0:2] = '{8'h20, 8'h30, 8'h90};
   logic [7:0]    ido [0:5] = '{8'h08, 8'h17, 8'h07, 8'h18, 8'h05, 8'h15};
   caod_note_type notes [$];
   caod_note_type mon;
   int            bad_count = 0;
   int            checks_done = 0;
   int            i, k;

`define CAOD_CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin bad_count++; \
   $display("ERROR %s expected %0h seen %0h", nm, ex, got); end end

   caod_core dut_u (
      .mclk(mclk), .sys_rst(sys_rst), .code_addr(code_addr), .code_rd(code_rd),
      .code_valid(code_valid), .code_data(code_data), .acc_out(acc_out), .b_out(b_out),
      .psw_out(psw_out), .sp_out(sp_out), .data_pointer_16(data_pointer_16),
      .insn_done(insn_done)
   );

   always #25 mclk = ~mclk;

   task automatic put(input logic [7:0] b);
      rom[pc] = b;
      pc++;
   endtask : put

   task automatic note();
      notes.push_back({ma, mb, {mcy, mac, 3'b000, mov, 1'b0, ^ma}, msp, mdp, pc});
   endtask : note

   task automatic alu(input int op, input logic [7:0] s);
      logic       c;
      logic [8:0] r;
      logic [4:0] h;
      c = (op != 0) && mcy;
      if (op == 2) begin
         r = {1'b0, ma} - s - c;
         h = {1'b0, ma[3:0]} - s[3:0] - c;
         mov = (ma[7] != s[7]) && (r[7] != ma[7]);
      end else begin
         r = {1'b0, ma} + s + c;
         h = {1'b0, ma[3:0]} + s[3:0] + c;
         mov = (ma[7] == s[7]) && (r[7] != ma[7]);
      end
      {mcy, mac, ma} = {r[8], h[4], r[7:0]};
   endtask : alu

   task automatic ar(input int op, input logic [7:0] lo, input logic [7:0] opnd,
                     input logic [7:0] s);
      put(grp[op] | lo);
      if (lo == 8'h04 || lo == 8'h05) put(opnd);
      alu(op, s);
      note();
   endtask : ar

   task automatic br(input logic take, input logic [7:0] rel);
      put(rel);
      if (take) pc = pc + {{8{rel[7]}}, rel};
      note();
   endtask : br

   task automatic push(input logic [15:0] r);
      msp++;
      ram[msp] = r[7:0];
      msp++;
      ram[msp] = r[15:8];
   endtask : push

   task automatic jump(input logic [7:0] op, input logic [15:0] dst);
      put(op);
      put(dst[15:8]);
      put(dst[7:0]);
      if (op == 8'h12) push(pc);
      pc = dst;
      note();
   endtask : jump

   task automatic print_verdict();
      if (bad_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : print_verdict

   // Code memory with random stalls; data is scrambled when not valid
   always @(negedge mclk) begin
      fv = code_rd && ($urandom % 4 != 0);
      code_valid <= fv;
      code_data <= fv ? rom[code_addr] : 8'($urandom);
   end

   always @(negedge mclk) begin
      if (!sys_rst && insn_done === 1'b1 && notes.size() > 0) begin
         mon = notes.pop_front();
         `CAOD_CHK("acc", mon.a, acc_out)
         `CAOD_CHK("b", mon.b, b_out)
         `CAOD_CHK("psw", mon.p, psw_out)
         `CAOD_CHK("sp", mon.s, sp_out)
         `CAOD_CHK("data_pointer_16", mon.d, data_pointer_16)
         `CAOD_CHK("pc", mon.pc, code_addr)
      end
   end

   initial begin
      #(25000 * 50);
      bad_count++;
      print_verdict();
   end

   initial begin
      void'($urandom(32'h5095_f02c));
      // Seed internal RAM so that register and memory operands are known values
      for (i = 0; i < 256; i++) begin
         ram[i] = 8'($urandom);
         dut_u.u_iram.mem[i] = ram[i];
      end
      {pc, mdp, ma, mb, msp, mcy, mac, mov} = {48'h0000_0000_0000, 8'h07, 3'b000};
      for (i = 0; i < 24; i++) begin
         v = 8'($urandom);
         ar(i % 3, 8'h04, v, v);
      end
      put(8'h84);
      {mcy, mov} = 2'b01;
      note();
      for (i = 0; i < 6; i++) begin
         put(i < 5 ? 8'h05 : 8'h15);
         put(8'hF0);
         mb = i < 5 ? mb + 8'h01 : mb - 8'h01;
         note();
      end
      ar(0, 8'h05, 8'hF0, mb);
      for (i = 0; i < 6; i++) begin
         put(i % 2 ? 8'hA4 : 8'h84);
         p = ma * mb;
         if (i % 2) {mb, ma, mov} = {p, p[15:8] != 0};
         else if (mb == 0) mov = 1'b1;
         else {ma, mb, mov} = {ma / mb, ma % mb, 1'b0};
         mcy = 1'b0;
         note();
      end
      for (i = 0; i < 6; i++) begin
         t = {4'($urandom % 10), 4'($urandom % 10)};
         v = {4'($urandom % 10), 4'($urandom % 10)};
         ar(0, 8'h04, t - ma, t - ma);
         ar(i % 2, 8'h04, v, v);
         put(8'hD4);
         w = {1'b0, ma};
         if (ma[3:0] > 4'h9 || mac) w = w + 9'h006;
         mcy = mcy | w[8];
         if (w[7:4] > 4'h9 || mcy) w = {1'b0, w[7:0]} + 9'h060;
         mcy = mcy | w[8];
         ma = w[7:0];
         note();
      end
      for (i = 0; i < 4; i++) begin
         put(i < 2 ? 8'h04 : 8'h14);
         ma = i < 2 ? ma + 8'h01 : ma - 8'h01;
         note();
      end
      put(8'h15);
      put(8'h82);
      mdp = 16'h00FF;
      note();
      put(8'hA3);
      mdp++;
      note();
      jump(8'h02, 16'h0842);
      jump(8'h12, 16'hF3A0);
      for (k = 0; k < 3; k++) begin
         ar(k, 8'h08, 8'h00, ram[0]);
         ar(k, 8'h07, 8'h00, ram[ram[1]]);
         ar(k, 8'h05, 8'h09, ram[9]);
      end
      for (i = 0; i < 6; i++) begin
         put(ido[i]);
         if (ido[i][2:0] == 3'h5) put(8'h00);
         v = ido[i][1] ? ram[1] : 8'h00;
         ram[v] = ido[i][4] ? ram[v] - 8'h01 : ram[v] + 8'h01;
         note();
         ar(0, 8'h08, 8'h00, ram[0]);
      end
      while (msp != 8'h1F) begin
         put(8'h05);
         put(8'h81);
         msp++;
         note();
      end
      jump(8'h12, 16'hC000);
      ar(0, 8'h05, 8'h21, ram[8'h21]);
      for (i = 0; i < 16; i++) begin
         v = i < 8 ? 8'(i) : 8'hE0 + 8'(i - 8);
         t = i < 8 ? ram[8'h20] : ma;
         k = $urandom % 2;
         put(k ? 8'h20 : 8'h30);
         put(v);
         br(t[v[2:0]] == k, 8'($urandom % 16));
      end
      for (i = 0; i < 8; i++) begin
         v = i % 4 == 2 ? 8'h00 - ma : 8'($urandom);
         ar(0, 8'h04, v, v);
         t = 8'(i % 4);
         put(8'h40 + 8'(16 * (i % 4)));
         br(t == 0 ? mcy : t == 1 ? !mcy : t == 2 ? ma == 0 : ma != 0, 8'($urandom % 32));
      end
      put(8'h80);
      br(1'b1, 8'h7F);
      put(8'h80);
      br(1'b1, 8'h80);
      jump(8'h02, 16'h17FE);
      p = 16'($urandom % 16'h0700);
      put({p[10:8], 5'h01});
      put(p[7:0]);
      pc = {pc[15:11], p[10:0]};
      note();
      put(8'hF1);
      put(8'hF0);
      push(pc);
      pc = {pc[15:11], 11'h7F0};
      note();
      ar(0, 8'h05, 8'h22, ram[8'h22]);
      put(8'h80);
      put(8'hFE);
      repeat (12) @(negedge mclk);
      `CAOD_CHK("rst_pc", 16'h0000, code_addr)
      `CAOD_CHK("rst_sp", 8'h07, sp_out)
      sys_rst = 1'b0;
      for (i = 0; i < 20000 && notes.size() > 0; i++) @(negedge mclk);
      `CAOD_CHK("left", 0, notes.size())
      print_verdict();
   end
endmodule : cpu_arith_operand_decode_bench

bind caod_core caod_core_props chk_u (
   .mclk(mclk), .sys_rst(sys_rst), .code_addr(code_addr), .code_rd(code_rd),
   .code_valid(code_valid), .code_data(code_data), .acc_out(acc_out), .b_out(b_out),
   .psw_out(psw_out), .sp_out(sp_out), .data_pointer_16(data_pointer_16),
   .insn_done(insn_done)
);
